/* hdl/bol_pkg.sv */
// Shared constants and types for the barrier ordering block
`default_nettype none
package bol_pkg;
    localparam int ID_W      = 4;
    localparam int ADDR_W    = 32;
    localparam int BAR_DEPTH = 256;
    localparam int LVL_W     = 9;
    localparam int IDX_W     = 8;
    localparam int CNT_W     = 8;
    localparam logic [LVL_W-1:0] LVL_RST   = 9'h000;
    localparam logic [LVL_W-1:0] LVL_DEPTH = 9'h100;
    localparam logic [CNT_W-1:0] CNT_RST   = 8'h00;
    localparam logic [IDX_W-1:0] IDX_RST   = 8'h00;
    localparam logic [ID_W-1:0]  ID_RST    = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    typedef enum logic [1:0] {
        BOL_IDLE,
        BOL_DRAIN,
        BOL_RESP
    } bol_state_t;
endpackage
`default_nettype wire

/* hdl/bol_bar_fifo.sv */
// Queue of write barrier IDs waiting for their read halves
`default_nettype none
module bol_bar_fifo
    import bol_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       push,
    input  wire logic [bol_pkg::ID_W-1:0]   pushData,
    input  wire logic                       pop,
    output logic      [bol_pkg::ID_W-1:0]   popData,
    output logic      [bol_pkg::LVL_W-1:0]  level
);
    logic [ID_W-1:0]  mem [BAR_DEPTH];
    logic [IDX_W-1:0] wrIdx;
    logic [IDX_W-1:0] rdIdx;
    logic [IDX_W-1:0] next_wrIdx;
    logic [IDX_W-1:0] next_rdIdx;
    logic [LVL_W-1:0] next_level;

    // Pointer and level update; caller never pushes when full
    always_comb
    begin
        next_wrIdx = push ? wrIdx + 8'h01 : wrIdx;
        next_rdIdx = pop ? rdIdx + 8'h01 : rdIdx;
        next_level = level + LVL_W'(push) - LVL_W'(pop);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrIdx <= IDX_RST;
            rdIdx <= IDX_RST;
            level <= LVL_RST;
        end
        else
        begin
            wrIdx <= next_wrIdx;
            rdIdx <= next_rdIdx;
            level <= next_level;
        end
    end

    // One storage entry per barrier slot
    for (genvar i = 0; i < BAR_DEPTH; i++)
    begin : g_entry
        logic [ID_W-1:0] next_entry;
        always_comb
        begin
            next_entry = (push && wrIdx == IDX_W'(i)) ? pushData : mem[i];
        end
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
                mem[i] <= ID_RST;
            else
                mem[i] <= next_entry;
        end
    end

    assign popData = mem[rdIdx];
endmodule
`default_nettype wire

/* hdl/bol_barrier_order.sv */
// Barrier ordering point on one ACE slave port
//
// Overview of operation
// - Traffic issued while a barrier is open has no ordering to it.
// - Snoop-completing writes may follow a write barrier and are accepted; here every write stalls while a pair drains or is answered.
// - Read channel stalls on a read barrier until its write half is here.
// - Accept 256 write barriers while writes keep flowing.
// - Read channel may stall on a read barrier.
// - Overlapping addresses from one start point take one path.
// - Barrier pairs leave in the same order on both channels.
// - Every slave port meets the barrier duties at once.
// - A barrier never overtakes earlier barrier-respecting traffic.
// - A barrier covers everything seen before it.
// - Non-barrier traffic may pass an unanswered barrier.
// - Hold read barrier until write half arrives and earlier writes drain.
// - Device ordering covers the whole peripheral, else all accesses.
// - Snoop response to a write only after all observers saw it.
`default_nettype none
module bol_barrier_order
    import bol_pkg::*;
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        arValid,
    output logic                             arReady,
    input  wire logic                        arBar,
    input  wire logic [bol_pkg::ID_W-1:0]    arId,
    input  wire logic [bol_pkg::ADDR_W-1:0]  arAddr,
    input  wire logic                        awValid,
    output logic                             awReady,
    input  wire logic                        awBar,
    input  wire logic [bol_pkg::ID_W-1:0]    awId,
    input  wire logic [bol_pkg::ADDR_W-1:0]  awAddr,
    output logic                             mArValid,
    input  wire logic                        mArReady,
    output logic      [bol_pkg::ID_W-1:0]    mArId,
    output logic      [bol_pkg::ADDR_W-1:0]  mArAddr,
    output logic                             mAwValid,
    input  wire logic                        mAwReady,
    output logic      [bol_pkg::ID_W-1:0]    mAwId,
    output logic      [bol_pkg::ADDR_W-1:0]  mAwAddr,
    input  wire logic                        rdDone,
    input  wire logic                        wrDone,
    output logic                             rBarValid,
    input  wire logic                        rBarReady,
    output logic      [bol_pkg::ID_W-1:0]    rBarId,
    output logic                             bBarValid,
    input  wire logic                        bBarReady,
    output logic      [bol_pkg::ID_W-1:0]    bBarId,
    input  wire logic                        snoopWrReq,
    input  wire logic                        allObserved,
    output logic                             snoopRespValid,
    input  wire logic                        snoopRespReady
);
    import bol_pkg::*;

    bol_state_t       state;
    bol_state_t       next_state;
    logic             next_arReady;
    logic             next_awReady;
    logic             next_mArValid;
    logic             next_mAwValid;
    logic [ID_W-1:0]  next_mArId;
    logic [ID_W-1:0]  next_mAwId;
    logic [ADDR_W-1:0] next_mArAddr;
    logic [ADDR_W-1:0] next_mAwAddr;
    logic             next_rBarValid;
    logic             next_bBarValid;
    logic [ID_W-1:0]  next_barId;
    logic [CNT_W-1:0] rdOut;
    logic [CNT_W-1:0] wrOut;
    logic [CNT_W-1:0] next_rdOut;
    logic [CNT_W-1:0] next_wrOut;
    logic             snoopPend;
    logic             next_snoopPend;
    logic             next_snoopResp;
    logic             arFire;
    logic             awFire;
    logic             wbarPush;
    logic             rbarPop;
    logic             drained;
    logic             pairOpenNext;
    logic             roomNext;
    logic [ID_W-1:0]  headId;
    logic [LVL_W-1:0] level;

    assign arFire   = arValid && arReady;
    assign awFire   = awValid && awReady;
    assign wbarPush = awFire && awBar;
    assign rbarPop  = arFire && arBar;
    assign drained  = rdOut == CNT_RST && wrOut == CNT_RST
                      && !mArValid && !mAwValid;

    // Write barriers parked until their read halves arrive
    bol_bar_fifo u_wbar (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .push     (wbarPush),
        .pushData (awId),
        .pop      (rbarPop),
        .popData  (headId),
        .level    (level)
    );

    // Barrier pair state: idle, drain earlier traffic, answer both halves
    always_comb
    begin
        next_state     = state;
        next_barId     = rBarId;
        next_rBarValid = rBarValid && !rBarReady;
        next_bBarValid = bBarValid && !bBarReady;
        case (state)
            BOL_IDLE:
            begin
                if (rbarPop)
                begin
                    next_state = BOL_DRAIN;
                    next_barId = arId;
                end
            end
            BOL_DRAIN:
            begin
                if (drained)
                begin
                    next_state     = BOL_RESP;
                    next_rBarValid = 1'b1;
                    next_bBarValid = 1'b1;
                end
            end
            BOL_RESP:
            begin
                if (!next_rBarValid && !next_bBarValid)
                    next_state = BOL_IDLE;
            end
            default:
                next_state = BOL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= BOL_IDLE;
            rBarId    <= ID_RST;
            bBarId    <= ID_RST;
            rBarValid <= 1'b0;
            bBarValid <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            rBarId    <= next_barId;
            bBarId    <= next_barId;
            rBarValid <= next_rBarValid;
            bBarValid <= next_bBarValid;
        end
    end

    // Forwarding slices, outstanding counts and upstream readies
    always_comb
    begin
        next_mArValid = mArValid && !mArReady;
        next_mArId    = mArId;
        next_mArAddr  = mArAddr;
        next_mAwValid = mAwValid && !mAwReady;
        next_mAwId    = mAwId;
        next_mAwAddr  = mAwAddr;
        if (arFire && !arBar)
        begin
            next_mArValid = 1'b1;
            next_mArId    = arId;
            next_mArAddr  = arAddr;
        end
        if (awFire && !awBar)
        begin
            next_mAwValid = 1'b1;
            next_mAwId    = awId;
            next_mAwAddr  = awAddr;
        end
        next_rdOut = rdOut + CNT_W'(mArValid && mArReady) - CNT_W'(rdDone);
        next_wrOut = wrOut + CNT_W'(mAwValid && mAwReady) - CNT_W'(wrDone);
        // Readies registered; read barriers wait for a parked write half
        pairOpenNext = (level != LVL_RST && !rbarPop) || wbarPush;
        roomNext     = (level + LVL_W'(wbarPush)) < LVL_DEPTH;
        next_arReady = next_state == BOL_IDLE && !next_mArValid
                       && (pairOpenNext
                           || (arValid && !arBar && !arFire));
        next_awReady = next_state == BOL_IDLE && !next_mAwValid
                       && (roomNext
                           || (awValid && !awBar && !awFire));
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mArValid <= 1'b0;
            mArId    <= ID_RST;
            mArAddr  <= ADDR_RST;
            mAwValid <= 1'b0;
            mAwId    <= ID_RST;
            mAwAddr  <= ADDR_RST;
            rdOut    <= CNT_RST;
            wrOut    <= CNT_RST;
            arReady  <= 1'b0;
            awReady  <= 1'b0;
        end
        else
        begin
            mArValid <= next_mArValid;
            mArId    <= next_mArId;
            mArAddr  <= next_mArAddr;
            mAwValid <= next_mAwValid;
            mAwId    <= next_mAwId;
            mAwAddr  <= next_mAwAddr;
            rdOut    <= next_rdOut;
            wrOut    <= next_wrOut;
            arReady  <= next_arReady;
            awReady  <= next_awReady;
        end
    end

    // Snoop response to a write waits until every observer has it
    always_comb
    begin
        next_snoopResp = (snoopRespValid && !snoopRespReady)
                         || (snoopPend && allObserved);
        next_snoopPend = snoopWrReq
                         || (snoopPend && !allObserved);     // Set wins
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            snoopPend      <= 1'b0;
            snoopRespValid <= 1'b0;
        end
        else
        begin
            snoopPend      <= next_snoopPend;
            snoopRespValid <= next_snoopResp;
        end
    end

    // Checks on ordering behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pairTaken;
        state == BOL_IDLE && rbarPop;
    endsequence
    sequence s_drainDone;
        state == BOL_DRAIN && drained;
    endsequence

    a_rbar_has_wbar : assert property (
        rbarPop |-> level != LVL_RST && headId == arId)
        else $error("read barrier taken without write half");
    a_wbar_room : assert property (
        wbarPush |-> level < LVL_DEPTH)
        else $error("write barrier queue overflow");
    a_no_overtake : assert property (
        $rose(rBarValid) |-> rdOut == CNT_RST && wrOut == CNT_RST)
        else $error("barrier answered before earlier traffic");
    a_drain_blocks : assert property (
        s_pairTaken |=> (!arFire && !awFire) [*2])
        else $error("traffic accepted while draining");
    a_drain_answers : assert property (
        s_drainDone |=> rBarValid && bBarValid && state == BOL_RESP)
        else $error("drained pair not answered next cycle");
    a_pair_same_id : assert property (
        s_pairTaken |=> ##[1:1000] $rose(rBarValid) && rBarId == bBarId)
        else $error("barrier halves answered with different IDs");
    a_resp_hold : assert property (
        rBarValid && !rBarReady |=> rBarValid && $stable(rBarId))
        else $error("read barrier response dropped");
    a_device_scope : assert property (
        $rose(bBarValid) |-> !mArValid && !mAwValid)
        else $error("barrier answered with traffic in flight");
    a_snoop_seen : assert property (
        $rose(snoopRespValid) |-> $past(allObserved))
        else $error("snoop response before observation");
    a_slice_path : assert property (
        mAwValid && !mAwReady |=> mAwValid && $stable(mAwAddr))
        else $error("forwarded write changed before taken");
endmodule
`default_nettype wire

/* testbench/bol_far_model.sv */
// Downstream slave model with random stalls and late completions
`default_nettype none
module bol_far_model
    import bol_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      mArValid,
    output logic                           mArReady,
    input  wire logic                      mAwValid,
    output logic                           mAwReady,
    output logic                           rdDone,
    output logic                           wrDone,
    output logic      [bol_pkg::LVL_W-1:0] pend
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0]      rnd;
    logic [LVL_W-1:0] rdPend;
    logic [LVL_W-1:0] wrPend;
    logic             rdGo;
    logic             wrGo;
    // Work still owed downstream, read by the bench
    assign pend = rdPend + wrPend;
    assign rdGo = rnd[1] && (rdPend != LVL_RST);
    assign wrGo = rnd[2] && (wrPend != LVL_RST);
    // Random stalls; at most one completion a cycle per channel
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rnd      <= 32'h1234_5679;
            rdPend   <= LVL_RST;
            wrPend   <= LVL_RST;
            mArReady <= 1'b0;
            mAwReady <= 1'b0;
            rdDone   <= 1'b0;
            wrDone   <= 1'b0;
        end
        else
        begin
            rnd      <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
            mArReady <= rnd[3] | rnd[4];
            mAwReady <= rnd[5] | rnd[6];
            rdDone   <= rdGo;
            wrDone   <= wrGo;
            rdPend   <= rdPend + LVL_W'(mArValid && mArReady)
                        - LVL_W'(rdGo);
            wrPend   <= wrPend + LVL_W'(mAwValid && mAwReady)
                        - LVL_W'(wrGo);
        end
    end
endmodule
`default_nettype wire

/* testbench/bol_barrier_order_tb_top.sv */
// Self-checking bench for the barrier ordering block
`default_nettype none
module bol_barrier_order_tb_top
    import bol_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              core_clk = 1'b0;
    logic              rst_n, arValid, arBar, awValid, awBar;
    logic              arReady, awReady, mArValid, mArReady;
    logic              mAwValid, mAwReady, rdDone, wrDone;
    logic              rBarValid, rBarReady, bBarValid, bBarReady;
    logic              snoopWrReq, allObserved, snoopRespValid, lastOk;
    logic              snoopRespReady;
    logic [ID_W-1:0]   arId, awId, mArId, mAwId, rBarId, bBarId;
    logic [ADDR_W-1:0] arAddr, awAddr, mArAddr, mAwAddr;
    logic [LVL_W-1:0]  pend;
    logic [31:0]       seed = 32'hb4a1e31e;
    logic [31:0]       rs;
    logic [35:0]       rdQ[$], wrQ[$];
    logic [3:0]        rbQ[$], bbQ[$];
    int                miscompares = 0;
    int                totalChecks = 0;
    bol_barrier_order u_bol_barrier_order (
        .core_clk(core_clk), .rst_n(rst_n), .arValid(arValid),
        .arReady(arReady), .arBar(arBar), .arId(arId), .arAddr(arAddr),
        .awValid(awValid), .awReady(awReady), .awBar(awBar), .awId(awId),
        .awAddr(awAddr), .mArValid(mArValid), .mArReady(mArReady),
        .mArId(mArId), .mArAddr(mArAddr), .mAwValid(mAwValid),
        .mAwReady(mAwReady), .mAwId(mAwId), .mAwAddr(mAwAddr),
        .rdDone(rdDone), .wrDone(wrDone), .rBarValid(rBarValid),
        .rBarReady(rBarReady), .rBarId(rBarId), .bBarValid(bBarValid),
        .bBarReady(bBarReady), .bBarId(bBarId), .snoopWrReq(snoopWrReq),
        .allObserved(allObserved), .snoopRespValid(snoopRespValid),
        .snoopRespReady(snoopRespReady));
    bol_far_model u_bol_far_model (.core_clk(core_clk), .rst_n(rst_n),
        .mArValid(mArValid), .mArReady(mArReady), .mAwValid(mAwValid),
        .mAwReady(mAwReady), .rdDone(rdDone), .wrDone(wrDone),
        .pend(pend));
    // Clock, 20 ns period
    always #10 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chkVec(input string nm, input logic [35:0] e, g);
        totalChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkBit(input string nm, input logic e, g);
        chkVec(nm, {35'h0, e}, {35'h0, g});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Request held until ready is seen at the taking edge
    task automatic sendA(input logic wr, b, input logic [3:0] id,
                         input logic [31:0] a);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        if (wr)
            {awValid, awBar, awId, awAddr} = {1'b1, b, id, a};
        else
            {arValid, arBar, arId, arAddr} = {1'b1, b, id, a};
        while (!(wr ? awReady : arReady) && n < 3000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        lastOk = (n < 3000);
        @(posedge core_clk);
        #1;
        if (wr)
            awValid = 1'b0;
        else
            arValid = 1'b0;
        if (!b && wr)
            wrQ.push_back({id, a});
        if (!b && !wr)
            rdQ.push_back({id, a});
        if (b && !wr)
            rbQ.push_back(id);
        if (b && !wr)
            bbQ.push_back(id);
    endtask
    task automatic randTraffic(input int cnt);
        repeat (cnt)
        begin
            seed = xs(seed);
            sendA(seed[0], 1'b0, {1'b0, seed[3:1]}, seed);
        end
    endtask
    // Random readiness for both barrier responses
    always @(posedge core_clk)
    begin
        #1;
        rs = xs(rs);
        rBarReady = rs[0] | rs[1];
        bBarReady = rs[2] | rs[3];
    end
    // Watch forwarded traffic and barrier answers before each taking edge
    always @(negedge core_clk)
    begin
        if (mArValid && mArReady)
            chkVec("mAr", rdQ.size() ? rdQ.pop_front() : 'x,
                   {mArId, mArAddr});
        if (mAwValid && mAwReady)
            chkVec("mAw", wrQ.size() ? wrQ.pop_front() : 'x,
                   {mAwId, mAwAddr});
        if (rBarValid && rBarReady)
            chkVec("rBarId", rbQ.size() ? rbQ.pop_front() : 'x, rBarId);
        if (bBarValid && bBarReady)
            chkVec("bBarId", bbQ.size() ? bbQ.pop_front() : 'x, bBarId);
        if (rBarValid && rBarReady)
            chkBit("drained", 1'b1, pend == LVL_RST);
    end
    // Hang guard sized well above the expected run
    initial
    begin
        #(20 * 90000);
        miscompares++;
        summarize();
    end
    initial
    begin
        rs = xs(seed);
        {rst_n, arValid, arBar, awValid, awBar} = 5'h00;
        {arId, awId, arAddr, awAddr} = 72'h0;
        {snoopWrReq, allObserved, rBarReady, bBarReady, snoopRespReady} = 5'h00;
        repeat (12) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        randTraffic(40);
        $display("test random traffic done");
        // Read half first: it must wait for its write half
        randTraffic(6);
        fork
            sendA(1'b0, 1'b1, 4'h9, 32'h0);
            begin
                repeat (8)
                begin
                    @(posedge core_clk);
                    #2;
                    chkBit("arStall", 1'b0, arReady);
                end
                sendA(1'b1, 1'b1, 4'h9, 32'h0);
            end
        join
        $display("test read half first done");
        // Full queue of write halves while writes keep flowing
        for (int i = 0; i < 256; i++)
            sendA(1'b1, 1'b1, {1'b1, 3'(i)}, 32'h0);
        sendA(1'b1, 1'b0, 4'h2, 32'h0000_0040);
        chkBit("awProgress", 1'b1, lastOk);
        for (int i = 0; i < 256; i++)
        begin
            if (i % 32 == 0)
                randTraffic(2);
            sendA(1'b0, 1'b1, {1'b1, 3'(i)}, 32'h0);
        end
        // Next traffic only once both answers of every pair are back
        while (rbQ.size() + bbQ.size() != 0)
            @(posedge core_clk);
        $display("test barrier queue done");
        // Snoop answer waits for all observers
        @(posedge core_clk);
        #1;
        snoopWrReq = 1'b1;
        @(posedge core_clk);
        #1;
        snoopWrReq = 1'b0;
        repeat (5)
        begin
            @(posedge core_clk);
            #2;
            chkBit("snpEarly", 1'b0, snoopRespValid);
        end
        @(posedge core_clk);
        #1;
        allObserved = 1'b1;
        // Answer rises one edge later and stands while not taken
        repeat (3)
        begin
            @(posedge core_clk);
            #2;
            chkBit("snpResp", 1'b1, snoopRespValid);
        end
        @(posedge core_clk);
        #1;
        {allObserved, snoopRespReady} = 2'b01;
        repeat (2) @(posedge core_clk);
        #2;
        chkBit("snpDone", 1'b0, snoopRespValid);
        repeat (300) @(posedge core_clk);
        chkVec("leftover", 36'h0, 36'(rdQ.size() + wrQ.size()
               + rbQ.size() + bbQ.size()));
        $display("test snoop and drain done");
        summarize();
    end
endmodule
`default_nettype wire
